//--- rtl/tcc_top.sv
// Capture and compare logic beside a free-running 16-bit timer
`timescale 1ns/1ns

module tcc_top
    import tcc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [15:0] timer_value_i,
    input wire logic timer_inc_i,
    input wire logic word_ovf_i,
    input wire logic byte_ovf_i,
    input wire logic [3:0] capture_input_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic [7:0] port4_pin_o,
    output logic [7:0] timer_irq_flags_o,
    output logic byte_overflow_flag_o,
    output logic [7:0] timer_irq_priority_o,
    output logic [7:0] timer_control_o,
    output logic [2:0] machine_state_o
);

    tcc_state_t state;
    logic [7:0] capture_edge_select;
    logic [5:0] compare_set_enable;
    logic [1:0] toggle_ff;
    logic [7:0] compare_reset_toggle_enable;
    logic [7:0] timer_irq_priority;
    logic [7:0] timer_control;
    logic [7:0] timer_irq_flags;
    logic [7:0] port4_latch;
    logic [15:0] compare_reg_set;
    logic [15:0] compare_reg_reset;
    logic [15:0] compare_reg_toggle;
    logic [15:0] capture_reg [4];
    logic [3:0] input_sample;
    logic [3:0] input_prev;
    logic [3:0] capture_pending;
    logic [2:0] match_now;
    logic [2:0] match_prev;
    logic word_ovf_pending;
    logic byte_ovf_pending;
    logic [3:0] edge_hit;
    logic [2:0] match_hit;
    logic end_of_cycle;
    logic wr_edge_select;
    logic wr_set_enable;
    logic wr_reset_toggle;
    logic wr_priority;
    logic wr_timer_control;
    logic wr_irq_flags;
    logic wr_port4;
    logic [7:0] next_port4_latch;
    logic [1:0] next_toggle_ff;
    logic [7:0] next_irq_flags;
    logic [7:0] flag_set;
    logic [7:0] read_mux;

    assign end_of_cycle = (state == TCC_S6);

    // Machine-cycle sequencer, six states of one clock each
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= TCC_S1;
        end
        else
        begin
            case (state)
                TCC_S1: state <= TCC_S2;
                TCC_S2: state <= TCC_S3;
                TCC_S3: state <= TCC_S4;
                TCC_S4: state <= TCC_S5;
                TCC_S5: state <= TCC_S6;
                default: state <= TCC_S1;
            endcase
        end
    end

    // Register write decode
    always_comb
    begin
        wr_edge_select = 1'b0;
        wr_set_enable = 1'b0;
        wr_reset_toggle = 1'b0;
        wr_priority = 1'b0;
        wr_timer_control = 1'b0;
        wr_irq_flags = 1'b0;
        wr_port4 = 1'b0;
        if (sfr_addr_i == TCC_ADDR_EDGE_SELECT)
        begin
            wr_edge_select = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_SET_ENABLE)
        begin
            wr_set_enable = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_RESET_TOGGLE)
        begin
            wr_reset_toggle = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_PRIORITY)
        begin
            wr_priority = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_TIMER_CONTROL)
        begin
            wr_timer_control = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_IRQ_FLAGS)
        begin
            wr_irq_flags = sfr_wr_i;
        end
        else if (sfr_addr_i == TCC_ADDR_PORT4)
        begin
            wr_port4 = sfr_wr_i;
        end
    end

    // Plain control registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            capture_edge_select <= TCC_RST_EDGE_SELECT;
            compare_set_enable <= TCC_RST_SET_ENABLE;
            compare_reset_toggle_enable <= TCC_RST_RESET_TOGGLE;
            timer_irq_priority <= TCC_RST_PRIORITY;
        end
        else
        begin
            if (wr_edge_select)
            begin
                capture_edge_select <= sfr_wdata_i;
            end
            if (wr_set_enable)
            begin
                // Bits 6 and 7 are the read-only toggle flip-flops
                compare_set_enable <= sfr_wdata_i[5:0];
            end
            if (wr_reset_toggle)
            begin
                compare_reset_toggle_enable <= sfr_wdata_i;
            end
            if (wr_priority)
            begin
                timer_irq_priority <= sfr_wdata_i;
            end
        end
    end

    // Compare registers, written a byte at a time
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            compare_reg_set <= TCC_RST_COMPARE;
            compare_reg_reset <= TCC_RST_COMPARE;
            compare_reg_toggle <= TCC_RST_COMPARE;
        end
        else if (sfr_wr_i)
        begin
            if (sfr_addr_i == TCC_ADDR_COMPARE_BASE)
            begin
                compare_reg_set[7:0] <= sfr_wdata_i;
            end
            else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h01)
            begin
                compare_reg_set[15:8] <= sfr_wdata_i;
            end
            else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h02)
            begin
                compare_reg_reset[7:0] <= sfr_wdata_i;
            end
            else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h03)
            begin
                compare_reg_reset[15:8] <= sfr_wdata_i;
            end
            else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h04)
            begin
                compare_reg_toggle[7:0] <= sfr_wdata_i;
            end
            else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h05)
            begin
                compare_reg_toggle[15:8] <= sfr_wdata_i;
            end
        end
    end

    // Capture inputs are looked at only in S1, so pulses shorter than a cycle may be missed
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            input_sample <= 4'h0;
            input_prev <= 4'h0;
        end
        else if (state == TCC_S1)
        begin
            input_sample <= capture_input_i;
            input_prev <= input_sample;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_capture
            // Edge seen between the last two S1 samples, judged once in S2
            assign edge_hit[ch] = (state == TCC_S2) && (
                (capture_edge_select[2*ch] && input_sample[ch] && !input_prev[ch]) ||
                (capture_edge_select[2*ch+1] && !input_sample[ch] && input_prev[ch])
            );

            always_ff @(posedge clk_sys_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    capture_pending[ch] <= 1'b0;
                    capture_reg[ch] <= TCC_RST_CAPTURE;
                end
                else if (edge_hit[ch])
                begin
                    capture_pending[ch] <= 1'b1;
                end
                else if (end_of_cycle && capture_pending[ch])
                begin
                    capture_pending[ch] <= 1'b0;
                    capture_reg[ch] <= timer_value_i;
                end
            end
        end
    endgenerate

    // Match against the timer value just after each increment
    assign match_hit[0] = timer_inc_i && (timer_value_i == compare_reg_set);
    assign match_hit[1] = timer_inc_i && (timer_value_i == compare_reg_reset);
    assign match_hit[2] = timer_inc_i && (timer_value_i == compare_reg_toggle);

    // Matches of this cycle move to the following cycle, where their effects land
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            match_now <= 3'h0;
            match_prev <= 3'h0;
            word_ovf_pending <= 1'b0;
            byte_ovf_pending <= 1'b0;
        end
        else if (end_of_cycle)
        begin
            match_now <= 3'h0;
            match_prev <= match_now | match_hit;
            word_ovf_pending <= 1'b0;
            byte_ovf_pending <= 1'b0;
        end
        else
        begin
            match_now <= match_now | match_hit;
            word_ovf_pending <= word_ovf_pending | word_ovf_i;
            byte_ovf_pending <= byte_ovf_pending | byte_ovf_i;
        end
    end

    // Port latch and toggle memory; hardware changes applied at the end of S4
    always_comb
    begin
        next_port4_latch = port4_latch;
        next_toggle_ff = toggle_ff;
        if (wr_port4)
        begin
            next_port4_latch = sfr_wdata_i;
        end
        if (state == TCC_S4)
        begin
            if (match_prev[0])
            begin
                next_port4_latch[5:0] = next_port4_latch[5:0] | compare_set_enable;
            end
            if (match_prev[1])
            begin
                // Applied after the set so a clash ends in reset
                next_port4_latch[5:0] = next_port4_latch[5:0] &
                    ~compare_reset_toggle_enable[5:0];
            end
            if (match_prev[2])
            begin
                for (int b = 0; b < 2; b++)
                begin
                    if (compare_reset_toggle_enable[TCC_BIT_TOGGLE_LO + b])
                    begin
                        next_port4_latch[TCC_BIT_TOGGLE_LO + b] = toggle_ff[b];
                        next_toggle_ff[b] = ~toggle_ff[b];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            port4_latch <= TCC_RST_PORT4;
            toggle_ff <= TCC_RST_TOGGLE_FF;
        end
        else
        begin
            port4_latch <= next_port4_latch;
            toggle_ff <= next_toggle_ff;
        end
    end

    // Pin follows a match in S5 and a software write in the next S1
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            port4_pin_o <= TCC_RST_PORT4;
        end
        else if (state == TCC_S4 && match_prev != 3'h0)
        begin
            port4_pin_o <= next_port4_latch;
        end
        else if (end_of_cycle)
        begin
            port4_pin_o <= next_port4_latch;
        end
    end

    // Flag set events, each timed to its state
    always_comb
    begin
        flag_set = 8'h00;
        if (state == TCC_S4)
        begin
            flag_set[1:0] = capture_pending[1:0];
        end
        if (end_of_cycle)
        begin
            flag_set[3:2] = capture_pending[3:2];
            flag_set[TCC_BIT_CMP_FLAG0 +: 3] = match_prev;
            flag_set[TCC_BIT_WORD_OVF] = word_ovf_pending | word_ovf_i;
        end
        // A set in the same cycle as a software clear wins
        next_irq_flags = (wr_irq_flags ? sfr_wdata_i : timer_irq_flags) | flag_set;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            timer_irq_flags <= TCC_RST_IRQ_FLAGS;
            timer_control <= TCC_RST_TIMER_CONTROL;
        end
        else
        begin
            timer_irq_flags <= next_irq_flags;
            if (wr_timer_control)
            begin
                timer_control <= sfr_wdata_i;
            end
            if (end_of_cycle && (byte_ovf_pending || byte_ovf_i))
            begin
                timer_control[TCC_BIT_BYTE_OVF] <= 1'b1;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        read_mux = 8'h00;
        if (sfr_addr_i == TCC_ADDR_EDGE_SELECT)
        begin
            read_mux = capture_edge_select;
        end
        else if (sfr_addr_i == TCC_ADDR_SET_ENABLE)
        begin
            read_mux = {toggle_ff[1], toggle_ff[0], compare_set_enable};
        end
        else if (sfr_addr_i == TCC_ADDR_RESET_TOGGLE)
        begin
            read_mux = compare_reset_toggle_enable;
        end
        else if (sfr_addr_i == TCC_ADDR_PRIORITY)
        begin
            read_mux = timer_irq_priority;
        end
        else if (sfr_addr_i == TCC_ADDR_TIMER_CONTROL)
        begin
            read_mux = timer_control;
        end
        else if (sfr_addr_i == TCC_ADDR_IRQ_FLAGS)
        begin
            read_mux = timer_irq_flags;
        end
        else if (sfr_addr_i == TCC_ADDR_PORT4)
        begin
            read_mux = port4_latch;
        end
        else if (sfr_addr_i[7:3] == TCC_ADDR_CAPTURE_BASE[7:3])
        begin
            read_mux = sfr_addr_i[0] ? capture_reg[sfr_addr_i[2:1]][15:8] :
                capture_reg[sfr_addr_i[2:1]][7:0];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE)
        begin
            read_mux = compare_reg_set[7:0];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h01)
        begin
            read_mux = compare_reg_set[15:8];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h02)
        begin
            read_mux = compare_reg_reset[7:0];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h03)
        begin
            read_mux = compare_reg_reset[15:8];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h04)
        begin
            read_mux = compare_reg_toggle[7:0];
        end
        else if (sfr_addr_i == TCC_ADDR_COMPARE_BASE + 8'h05)
        begin
            read_mux = compare_reg_toggle[15:8];
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sfr_rdata_o <= 8'h00;
            timer_irq_flags_o <= TCC_RST_IRQ_FLAGS;
            byte_overflow_flag_o <= 1'b0;
            timer_irq_priority_o <= TCC_RST_PRIORITY;
            timer_control_o <= TCC_RST_TIMER_CONTROL;
            machine_state_o <= 3'h0;
        end
        else
        begin
            if (sfr_rd_i)
            begin
                sfr_rdata_o <= read_mux;
            end
            timer_irq_flags_o <= timer_irq_flags;
            byte_overflow_flag_o <= timer_control[TCC_BIT_BYTE_OVF];
            timer_irq_priority_o <= timer_irq_priority;
            timer_control_o <= timer_control;
            machine_state_o <= state;
        end
    end

endmodule // tcc_top

//--- rtl/tcc_pkg.sv
// Constants and types for the timer capture and compare unit
package tcc_pkg;

    // Machine-cycle states, one system clock each
    typedef enum logic [2:0] {TCC_S1, TCC_S2, TCC_S3, TCC_S4, TCC_S5, TCC_S6} tcc_state_t;

    // Special function register addresses
    localparam logic [7:0] TCC_ADDR_IRQ_FLAGS = 8'hc8;
    localparam logic [7:0] TCC_ADDR_TIMER_CONTROL = 8'hea;
    localparam logic [7:0] TCC_ADDR_EDGE_SELECT = 8'heb;
    localparam logic [7:0] TCC_ADDR_SET_ENABLE = 8'hee;
    localparam logic [7:0] TCC_ADDR_RESET_TOGGLE = 8'hef;
    localparam logic [7:0] TCC_ADDR_PRIORITY = 8'hf8;
    localparam logic [7:0] TCC_ADDR_PORT4 = 8'hc0;
    // Capture registers, low byte at base + 2n, high byte at base + 2n + 1
    localparam logic [7:0] TCC_ADDR_CAPTURE_BASE = 8'ha0;
    // Compare registers set, reset, toggle, low byte at base + 2n
    localparam logic [7:0] TCC_ADDR_COMPARE_BASE = 8'hb0;

    // Values after reset
    localparam logic [7:0] TCC_RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] TCC_RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] TCC_RST_EDGE_SELECT = 8'h00;
    localparam logic [5:0] TCC_RST_SET_ENABLE = 6'h00;
    localparam logic [1:0] TCC_RST_TOGGLE_FF = 2'h3;
    localparam logic [7:0] TCC_RST_RESET_TOGGLE = 8'h00;
    localparam logic [7:0] TCC_RST_PRIORITY = 8'h00;
    localparam logic [7:0] TCC_RST_PORT4 = 8'h00;
    localparam logic [15:0] TCC_RST_COMPARE = 16'h0000;
    localparam logic [15:0] TCC_RST_CAPTURE = 16'h0000;

    // Field positions
    localparam int TCC_BIT_BYTE_OVF = 4;
    localparam int TCC_BIT_WORD_OVF = 7;
    localparam int TCC_BIT_CMP_FLAG0 = 4;
    localparam int TCC_BIT_TOGGLE_LO = 6;
    localparam int TCC_NUM_SET_RESET_BITS = 6;

endpackage

//--- tb/tcc_ext_model.sv
// Far-side model: free-running timer source and capture event drivers
`timescale 1ns/1ns
module tcc_ext_model
(
    input wire logic clk_sys_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic [3:0] event_lvl_i,
    output logic [15:0] timer_value_o,
    output logic timer_inc_o,
    output logic word_ovf_o,
    output logic byte_ovf_o,
    output logic [3:0] capture_input_o
);
    logic [2:0] phase = 3'h0;
    logic run_q = 1'b0;
    logic load_q = 1'b0;
    logic [15:0] load_val_q = 16'h0000;
    logic [3:0] event_q = 4'h0;
    // Controls are taken at the rising edge so the bench's falling-edge writes never race
    always @(posedge clk_sys_i)
    begin
        run_q <= run_i;
        load_q <= load_i;
        load_val_q <= load_val_i;
        event_q <= event_lvl_i;
    end
    initial
    begin
        timer_value_o = 16'h0000;
        timer_inc_o = 1'b0;
        word_ovf_o = 1'b0;
        byte_ovf_o = 1'b0;
        capture_input_o = 4'h0;
    end
    // Falling edge updates keep every sampled input settled; one step per machine cycle
    always @(negedge clk_sys_i)
    begin
        capture_input_o <= event_q;
        timer_inc_o <= 1'b0;
        word_ovf_o <= 1'b0;
        byte_ovf_o <= 1'b0;
        if (load_q)
        begin
            timer_value_o <= load_val_q;
            phase <= 3'h0;
        end
        else if (run_q)
        begin
            phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            if (phase == 3'h5)
            begin
                timer_value_o <= timer_value_o + 16'h0001;
                timer_inc_o <= 1'b1;
                byte_ovf_o <= (timer_value_o[7:0] == 8'hff);
                word_ovf_o <= (timer_value_o == 16'hffff);
            end
        end
    end
endmodule // tcc_ext_model

//--- tb/tcc_top_sva.sv
// Assertions on the ports of the capture and compare unit
`timescale 1ns/1ns
module tcc_top_sva
    import tcc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [15:0] timer_value_i,
    input wire logic timer_inc_i,
    input wire logic word_ovf_i,
    input wire logic byte_ovf_i,
    input wire logic [3:0] capture_input_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] port4_pin_o,
    input wire logic [7:0] timer_irq_flags_o,
    input wire logic byte_overflow_flag_o,
    input wire logic [7:0] timer_irq_priority_o,
    input wire logic [7:0] timer_control_o,
    input wire logic [2:0] machine_state_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    a_state_cycles: assert property (
        $past(arst_n_i, 2) |-> machine_state_o == (($past(machine_state_o) == 3'h5) ?
        3'h0 : $past(machine_state_o) + 3'h1)) else $error("machine state out of sequence");
    a_prio_write: assert property (
        sfr_wr_i && sfr_addr_i == TCC_ADDR_PRIORITY |-> ##2
        timer_irq_priority_o == $past(sfr_wdata_i, 2)) else $error("priority not stored");
    a_word_ovf_flag: assert property (
        word_ovf_i |-> ##[1:8] timer_irq_flags_o[7]) else $error("word overflow flag missing");
    a_byte_ovf_flag: assert property (
        byte_ovf_i |-> ##[1:8] byte_overflow_flag_o) else $error("byte overflow flag missing");
    a_ninth_flag_home: assert property (
        byte_overflow_flag_o == timer_control_o[4]) else $error("byte flag not in control bit");
    a_early_cap_slot: assert property (
        $rose(timer_irq_flags_o[0]) || $rose(timer_irq_flags_o[1]) |->
        machine_state_o == 3'h4) else $error("capture flag 0 or 1 set in wrong state");
    a_late_flag_slot: assert property (
        (timer_irq_flags_o[7:2] & ~$past(timer_irq_flags_o[7:2])) != 6'h00 |->
        machine_state_o == 3'h0) else $error("late flag set in wrong state");
    a_pin_slot: assert property (
        $past(arst_n_i) && port4_pin_o != $past(port4_pin_o) |->
        machine_state_o inside {3'h3, 3'h5}) else $error("port pin changed in wrong state");
endmodule // tcc_top_sva

bind tcc_top tcc_top_sva i_sva (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .timer_value_i(timer_value_i), .timer_inc_i(timer_inc_i), .word_ovf_i(word_ovf_i),
    .byte_ovf_i(byte_ovf_i), .capture_input_i(capture_input_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .port4_pin_o(port4_pin_o), .timer_irq_flags_o(timer_irq_flags_o),
    .byte_overflow_flag_o(byte_overflow_flag_o), .timer_irq_priority_o(timer_irq_priority_o),
    .timer_control_o(timer_control_o), .machine_state_o(machine_state_o));

//--- tb/tb.sv
// Self-checking bench for the capture and compare unit
`timescale 1ns/1ns
module tb
    import tcc_pkg::*;
;
    logic clk_sys_i;
    logic arst_n_i;
    logic [7:0] addr, wdata, rdata, pin, flags, prio, tctl;
    logic wr_en, rd_en, byte_flag, run, load, t_inc, w_ovf, b_ovf;
    logic [15:0] load_val, tval;
    logic [3:0] event_lvl, cap_in;
    logic [15:0] exp_cap [4];
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    tcc_top i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .timer_value_i(tval),
        .timer_inc_i(t_inc), .word_ovf_i(w_ovf), .byte_ovf_i(b_ovf), .capture_input_i(cap_in),
        .sfr_addr_i(addr), .sfr_wr_i(wr_en), .sfr_rd_i(rd_en), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .port4_pin_o(pin), .timer_irq_flags_o(flags),
        .byte_overflow_flag_o(byte_flag), .timer_irq_priority_o(prio),
        .timer_control_o(tctl), .machine_state_o());
    tcc_ext_model i_ext (.clk_sys_i(clk_sys_i), .run_i(run), .load_i(load),
        .load_val_i(load_val), .event_lvl_i(event_lvl), .timer_value_o(tval),
        .timer_inc_o(t_inc), .word_ovf_o(w_ovf), .byte_ovf_o(b_ovf), .capture_input_o(cap_in));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Ceiling well above the twelve hundred or so cycles the tests need
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("unexpected at %0t: timeout %h %h", $time, cycles, 20000);
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk_sys_i);
        wr_en = 1'b0;
    endtask

    // Read data is registered, so it is taken one clock after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk_sys_i);
        rd_en = 1'b0;
        d = rdata;
    endtask

    task automatic set_timer(input logic [15:0] v);
        @(negedge clk_sys_i);
        load_val = v;
        load = 1'b1;
        @(negedge clk_sys_i);
        load = 1'b0;
    endtask

    task automatic t_reset;
        logic [7:0] d;
        rd(TCC_ADDR_SET_ENABLE, d);
        check(d, 8'hc0);
        rd(TCC_ADDR_EDGE_SELECT, d);
        check(d, 8'h00);
        rd(TCC_ADDR_RESET_TOGGLE, d);
        check(d, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rd(TCC_ADDR_COMPARE_BASE + 8'(i), d);
            check(d, 8'h00);
        end
        rd(8'h10, d);
        check(d, 8'h00);
        check(pin, 8'h00);
        $display("reset test done");
    endtask

    // Every channel against every edge mode, both input directions
    task automatic t_capture;
        logic [7:0] lo, hi, d;
        logic [1:0] mode;
        for (int n = 0; n < 4; n++)
            for (int m = 0; m < 4; m++)
                for (int e = 0; e < 2; e++)
                begin
                    mode = 2'(m);
                    wr(TCC_ADDR_EDGE_SELECT, 8'(mode) << (2 * n));
                    wr(TCC_ADDR_IRQ_FLAGS, 8'h00);
                    set_timer({4'(n), 4'(m), 8'(e + 1)});
                    event_lvl[n] = (e == 0);
                    idle(20);
                    rd(TCC_ADDR_IRQ_FLAGS, d);
                    check(d, {7'h00, mode[e]} << n);
                    if (mode[e])
                        exp_cap[n] = load_val;
                    rd(TCC_ADDR_CAPTURE_BASE + 8'(2 * n), lo);
                    rd(TCC_ADDR_CAPTURE_BASE + 8'(2 * n + 1), hi);
                    check({hi, lo}, exp_cap[n]);
                end
        $display("capture test done");
    endtask

    task automatic t_compare;
        logic [7:0] d;
        wr(TCC_ADDR_SET_ENABLE, 8'hff);
        wr(TCC_ADDR_RESET_TOGGLE, 8'hc5);
        for (int i = 0; i < 6; i += 2)
        begin
            wr(TCC_ADDR_COMPARE_BASE + 8'(i), 8'hf2);
            wr(TCC_ADDR_COMPARE_BASE + 8'(i + 1), 8'h00);
        end
        wr(TCC_ADDR_IRQ_FLAGS, 8'h00);
        set_timer(16'h00f0);
        run = 1'b1;
        idle(42);
        check(pin, 8'hfa);
        rd(TCC_ADDR_IRQ_FLAGS, d);
        check(d, 8'h70);
        rd(TCC_ADDR_SET_ENABLE, d);
        check(d, 8'h3f);
        run = 1'b0;
        wr(TCC_ADDR_PORT4, 8'hff);
        idle(7);
        check(pin, 8'hff);
        set_timer(16'h00f0);
        run = 1'b1;
        idle(42);
        run = 1'b0;
        check(pin, 8'h3a);
        rd(TCC_ADDR_SET_ENABLE, d);
        check(d, 8'hff);
        $display("compare test done");
    endtask

    task automatic t_overflow;
        logic [7:0] d;
        wr(TCC_ADDR_IRQ_FLAGS, 8'h00);
        set_timer(16'hfffe);
        run = 1'b1;
        idle(20);
        run = 1'b0;
        rd(TCC_ADDR_IRQ_FLAGS, d);
        check(d, 8'h80);
        check(flags, 8'h80);
        check(byte_flag, 1'b1);
        rd(TCC_ADDR_TIMER_CONTROL, d);
        check(d, 8'h10);
        check(tctl, 8'h10);
        wr(TCC_ADDR_PRIORITY, 8'h5a);
        rd(TCC_ADDR_PRIORITY, d);
        check(d, 8'h5a);
        check(prio, 8'h5a);
        $display("overflow test done");
    endtask

    initial
    begin
        arst_n_i = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        run = 1'b0;
        load = 1'b0;
        load_val = 16'h0000;
        event_lvl = 4'h0;
        for (int i = 0; i < 4; i++)
            exp_cap[i] = 16'h0000;
        repeat (20) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        t_reset();
        t_capture();
        t_compare();
        t_overflow();
        tally_and_finish();
    end
endmodule // tb
